// file: pkg/upac_pkg.sv
// Constants and types for the port Active-mode controller.
// Assumes a single 125 MHz clock domain and compile before all logic files.
package upac_pkg;

  // ----------------------------------------------------------------
  // Mode codes, bit order {modeSelectA, modeSelectB, emulationEnable}
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_DCE_A = 3'h0;
  localparam logic [2:0] CODE_PASS_A = 3'h1;
  localparam logic [2:0] CODE_PASS_B = 3'h2;
  localparam logic [2:0] CODE_DCP = 3'h3;
  localparam logic [2:0] CODE_SDP = 3'h4;
  localparam logic [2:0] CODE_DCE_B = 3'h5;
  localparam logic [2:0] CODE_PASS_C = 3'h6;
  localparam logic [2:0] CODE_CDP = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int RESP_TIME_MS = 20;
  localparam int RESP_CYC = RESP_TIME_MS * 1000 * CLK_MHZ;
  localparam int DISCH_CYC = 64;
  localparam int EMU_TIMEOUT_CYC = 256;
  localparam int CNT_W = 16;
  localparam int RESP_CNT_W = 22;

  // ----------------------------------------------------------------
  // Types and reset values
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {MODE_PASS, MODE_SDP, MODE_CDP, MODE_DCP, MODE_DCE} upac_mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_DISCH, ST_CHECK, ST_RUN, ST_DCE_WAIT, ST_ERROR} upac_seq_t;
  localparam upac_mode_t MODE_RST = MODE_PASS;
  localparam upac_seq_t SEQ_RST = ST_IDLE;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

endpackage

// file: logic/upac_sync.sv
// Two-flop synchroniser bank for asynchronous pins.
// Assumes sys_clk domain; clkEn freezes both stages.
module upac_sync #(
  parameter int Width = 1
) (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Sync reset, active high
  input wire logic clkEn, // Clock enable
  input wire logic [Width-1:0] asyncIn, // Raw pins
  output logic [Width-1:0] syncOut // Synchronised levels
);

  // ----------------------------------------------------------------
  // One pair of flops per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < Width; i++) begin : gBit
      logic meta;
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          meta <= 1'b0;
          syncOut[i] <= 1'b0;
        end else if (clkEn) begin
          meta <= asyncIn[i];
          syncOut[i] <= meta;
        end
      end
    end
  endgenerate

endmodule

// file: logic/upac_active_ctrl.sv
// Active-mode sequencer of a USB port power controller.
// Assumes analog comparators and switches outside; all pin inputs are asynchronous.
//
// Summary of operation
// RL1 - Decode mode pins into standard, emulation cycle, charging-downstream or dedicated modes.
// RL2 - Patterns 010 and 110 are pass-through, kept even with power enable low.
// RL3 - Host raises power enable before changing mode pins to leave pass-through.
// RL4 - Pass-through closes data switch, trip limiting, no profile, until mode changes.
// RL5 - Entering pass-through never discharges VBUS.
// RL6 - Standard-port mode equals pass-through preceded by a VBUS discharge.
// RL7 - Standard-port entry discharges, closes switch, trip limit; held until inputs change.
// RL8 - Changing between standard, dedicated, downstream modes cycles VBUS.
// RL9 - Downstream entry discharges VBUS, closes switch, then applies handshake profile.
// RL10 - Downstream mode keeps constant-current limit and profile even if handshake fails.
// RL11 - Downstream handshake runs with data switch closed after VBUS applied.
// RL12 - D+ in primary window makes block drive 0.6 V on D- within 20 ms.
// RL13 - D+ back to zero makes block release D- within 20 ms.
// RL14 - Secondary detection on D- needs no action; D+ stays zero.
// RL15 - Downstream mode answers renegotiation requests from the attached device.
// RL16 - Power-only load gives no removal; power toggle or mode change forces removal.
// RL17 - Dedicated mode discharges, applies short, disables timeout and draw requirement.
// RL18 - Dedicated profile inside emulation cycle enables timeout and draw requirement.
// RL19 - Charging after dedicated profile keeps short, switch open, constant-current limit.
// RL20 - Dedicated profile applies VBUS and short resistor, nothing else on D+/D-.
// RL21 - Host sets detect select low for plain switch use or compliance testing.
// RL22 - After each discharge check VBUS low, else flag error and enter error state.
// RL23 - Charging modes use constant-current when limit is at most 1.5 A.
// RL24 - Synchronise mode and power pins; any decoded mode change reruns entry.
module upac_active_ctrl #(
  parameter int DischCyc = upac_pkg::DISCH_CYC,
  parameter int EmuTimeoutCyc = upac_pkg::EMU_TIMEOUT_CYC,
  parameter int RespLimitCyc = upac_pkg::RESP_CYC
) (
  input wire logic sys_clk, // System clock, 125 MHz
  input wire logic sys_rst, // Sync reset, active high
  input wire logic clkEn, // Clock enable, freezes all state
  input wire logic modeSelectA, // Mode pin A
  input wire logic modeSelectB, // Mode pin B
  input wire logic emulationEnableInput, // Emulation enable pin
  input wire logic portPowerEnable, // Port power enable pin
  input wire logic detectFeatureSelect, // Attach/removal detection on
  input wire logic dplusPrimary, // D+ within 0.4..0.8 V comparator
  input wire logic dplusLow, // D+ at logic zero comparator
  input wire logic vbusBelowTest, // VBUS below test level comparator
  input wire logic chargeCurrentDrawn, // Load draws charge current
  input wire logic currentLimitSettingLow, // Current limit at most 1.5 A
  output logic portSwitchOn, // Port power switch closed
  output logic vbusDischarge, // VBUS discharge resistor on
  output logic hsSwitchClosed, // High-speed data switch closed
  output logic ccLimitMode, // 1 constant-current, 0 trip
  output logic dminusDrive, // Drive 0.6 V on D-
  output logic dcpShortResistor, // Short resistor D+ to D-
  output logic emuTimeoutEnable, // Emulation timeout active
  output logic currentDrawRequired, // Current draw required
  output logic dischargeError, // Discharge error, error state
  output logic dcpDetected, // Dedicated profile accepted in cycle
  output logic cdpHandshakeDone, // Primary handshake completed
  output logic removalEvent, // One-cycle removal and re-arm pulse
  output logic [2:0] activeMode // Current decoded mode
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [9:0] rawIn;
  logic [9:0] syncIn;
  logic selA, selB, emEn, pwrEn, detEn, dpPrim, dpLow, vbusLow, charging, limLow;

  assign rawIn = {modeSelectA, modeSelectB, emulationEnableInput, portPowerEnable,
                  detectFeatureSelect, dplusPrimary, dplusLow, vbusBelowTest,
                  chargeCurrentDrawn, currentLimitSettingLow};

  upac_sync #(.Width(10)) uSync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .asyncIn(rawIn),
    .syncOut(syncIn)
  ); // [RL24]

  assign {selA, selB, emEn, pwrEn, detEn, dpPrim, dpLow, vbusLow, charging, limLow} = syncIn;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  upac_pkg::upac_mode_t modeDec;

  always_comb begin
    case ({selA, selB, emEn})
      upac_pkg::CODE_SDP: modeDec = upac_pkg::MODE_SDP; // [RL1]
      upac_pkg::CODE_DCE_A, upac_pkg::CODE_DCE_B: modeDec = upac_pkg::MODE_DCE; // [RL1]
      upac_pkg::CODE_CDP: modeDec = upac_pkg::MODE_CDP; // [RL1]
      upac_pkg::CODE_DCP: modeDec = upac_pkg::MODE_DCP; // [RL1]
      upac_pkg::CODE_PASS_B, upac_pkg::CODE_PASS_C: modeDec = upac_pkg::MODE_PASS; // [RL2]
      default: modeDec = upac_pkg::MODE_PASS;
    endcase
  end

  // ----------------------------------------------------------------
  // Entry detection
  // ----------------------------------------------------------------
  upac_pkg::upac_mode_t curMode_r;
  upac_pkg::upac_seq_t seq_r;
  logic [upac_pkg::CNT_W-1:0] cnt_r;
  logic modeKnown_r;
  logic pwrEnD_r;
  logic [1:0] syncFill_r;
  logic syncValid;
  logic modeChange, pwrRise, pwrFall, reEntry, curPass;

  // Synchroniser zeros after reset decode as a mode; wait until real pins arrive
  assign syncValid = syncFill_r[1];
  assign modeChange = !modeKnown_r || (modeDec != curMode_r); // [RL24]
  assign pwrRise = pwrEn && !pwrEnD_r;
  assign pwrFall = !pwrEn && pwrEnD_r;
  // Power rise re-enters a powered mode, so VBUS is cycled again
  assign reEntry = syncValid
                   && (modeChange || (pwrRise && modeDec != upac_pkg::MODE_PASS)); // [RL7] [RL8]
  assign curPass = (curMode_r == upac_pkg::MODE_PASS);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      curMode_r <= upac_pkg::MODE_RST;
      modeKnown_r <= 1'b0;
      pwrEnD_r <= 1'b0;
      syncFill_r <= 2'h0;
    end else if (clkEn) begin
      curMode_r <= modeDec;
      modeKnown_r <= syncValid;
      pwrEnD_r <= pwrEn;
      syncFill_r <= {syncFill_r[0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Entry sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seq_r <= upac_pkg::SEQ_RST;
      cnt_r <= upac_pkg::CNT_RST;
    end else if (clkEn) begin
      if (reEntry) begin
        cnt_r <= upac_pkg::CNT_RST;
        if (modeDec == upac_pkg::MODE_PASS) begin
          seq_r <= upac_pkg::ST_RUN; // [RL5] [RL4]
        end else begin
          seq_r <= upac_pkg::ST_DISCH; // [RL6] [RL9] [RL17] [RL8]
        end
      end else if (pwrFall && !curPass) begin
        // Pass-through alone survives power enable going low
        seq_r <= upac_pkg::ST_IDLE; // [RL2]
      end else begin
        case (seq_r)
          upac_pkg::ST_DISCH: begin
            if (cnt_r == upac_pkg::CNT_W'(DischCyc - 1)) begin
              seq_r <= upac_pkg::ST_CHECK;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
          upac_pkg::ST_CHECK: begin
            cnt_r <= upac_pkg::CNT_RST;
            if (!vbusLow) begin
              seq_r <= upac_pkg::ST_ERROR; // [RL22]
            end else if (curMode_r == upac_pkg::MODE_DCE) begin
              seq_r <= upac_pkg::ST_DCE_WAIT; // [RL18]
            end else begin
              seq_r <= upac_pkg::ST_RUN;
            end
          end
          upac_pkg::ST_DCE_WAIT: begin
            if (charging) begin
              seq_r <= upac_pkg::ST_RUN; // [RL19]
            end else if (cnt_r == upac_pkg::CNT_W'(EmuTimeoutCyc - 1)) begin
              // No draw: emulation reset and retry while power stays enabled
              cnt_r <= upac_pkg::CNT_RST;
              seq_r <= pwrEn ? upac_pkg::ST_DISCH : upac_pkg::ST_IDLE; // [RL18]
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
          upac_pkg::ST_IDLE, upac_pkg::ST_RUN, upac_pkg::ST_ERROR: seq_r <= seq_r;
          default: seq_r <= upac_pkg::SEQ_RST;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Port outputs
  // ----------------------------------------------------------------
  logic running, profileOn, chargeMode;
  logic portSwitch_nxt, hsSwitch_nxt, ccLimit_nxt, dcpShort_nxt, emuTimeout_nxt;

  assign running = (seq_r == upac_pkg::ST_RUN);
  assign profileOn = running || (seq_r == upac_pkg::ST_DCE_WAIT);
  assign chargeMode = (curMode_r == upac_pkg::MODE_CDP) || (curMode_r == upac_pkg::MODE_DCP)
                      || (curMode_r == upac_pkg::MODE_DCE);

  always_comb begin
    portSwitch_nxt = profileOn && (pwrEn || curPass); // [RL2] [RL20]
    hsSwitch_nxt = running && (curPass || curMode_r == upac_pkg::MODE_SDP
                   || curMode_r == upac_pkg::MODE_CDP); // [RL4] [RL7] [RL11]
    ccLimit_nxt = profileOn && chargeMode && limLow; // [RL23] [RL10] [RL19]
    dcpShort_nxt = profileOn && (curMode_r == upac_pkg::MODE_DCP
                   || curMode_r == upac_pkg::MODE_DCE); // [RL20] [RL19]
    emuTimeout_nxt = (curMode_r == upac_pkg::MODE_DCE); // [RL17] [RL18]
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      portSwitchOn <= 1'b0;
      vbusDischarge <= 1'b0;
      hsSwitchClosed <= 1'b0;
      ccLimitMode <= 1'b0;
      dcpShortResistor <= 1'b0;
      emuTimeoutEnable <= 1'b0;
      currentDrawRequired <= 1'b0;
      dischargeError <= 1'b0;
      activeMode <= 3'h0;
    end else if (clkEn) begin
      portSwitchOn <= portSwitch_nxt;
      vbusDischarge <= (seq_r == upac_pkg::ST_DISCH);
      hsSwitchClosed <= hsSwitch_nxt;
      ccLimitMode <= ccLimit_nxt;
      dcpShortResistor <= dcpShort_nxt;
      emuTimeoutEnable <= emuTimeout_nxt;
      currentDrawRequired <= emuTimeout_nxt;
      dischargeError <= (seq_r == upac_pkg::ST_ERROR); // [RL22]
      activeMode <= curMode_r;
    end
  end

  // ----------------------------------------------------------------
  // Downstream-port handshake
  // ----------------------------------------------------------------
  logic cdpActive;
  assign cdpActive = running && (curMode_r == upac_pkg::MODE_CDP) && !reEntry;

  // Stays armed after completion, so renegotiation is answered the same way
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dminusDrive <= 1'b0;
      cdpHandshakeDone <= 1'b0;
    end else if (clkEn) begin
      if (!cdpActive) begin
        dminusDrive <= 1'b0;
        cdpHandshakeDone <= 1'b0;
      end else if (dpPrim) begin
        dminusDrive <= 1'b1; // [RL12] [RL15]
      end else if (dpLow && dminusDrive) begin
        // D- secondary drive from the load is ignored; D+ is never driven
        dminusDrive <= 1'b0; // [RL13] [RL14]
        cdpHandshakeDone <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Accept flag and removal pulse
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dcpDetected <= 1'b0;
    end else if (clkEn) begin
      if (reEntry) begin
        dcpDetected <= 1'b0;
      end else if (seq_r == upac_pkg::ST_DCE_WAIT && charging) begin
        dcpDetected <= 1'b1; // [RL19]
      end
    end
  end

  // A silent power-only load never raises this; only host action forces it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      removalEvent <= 1'b0;
    end else if (clkEn) begin
      removalEvent <= detEn && modeKnown_r && curMode_r == upac_pkg::MODE_CDP
                      && (modeChange || pwrRise || pwrFall); // [RL16]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [upac_pkg::RESP_CNT_W-1:0] respCnt_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      respCnt_r <= '0;
    end else if (clkEn) begin
      if (cdpActive && dpPrim && !dminusDrive) begin
        respCnt_r <= respCnt_r + 1'b1;
      end else begin
        respCnt_r <= '0;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst || !clkEn);

  sequence sPassEntry;
    reEntry && modeDec == upac_pkg::MODE_PASS;
  endsequence

  sequence sDischEntry;
    reEntry && modeDec != upac_pkg::MODE_PASS;
  endsequence

  sequence sCdpPrimary;
    cdpActive && dpPrim;
  endsequence

  sequence sDceTimeout;
    seq_r == upac_pkg::ST_DCE_WAIT && !charging && pwrEn && !reEntry && !pwrFall
    && cnt_r == upac_pkg::CNT_W'(EmuTimeoutCyc - 1);
  endsequence

  chk_pass_no_discharge: assert property (sPassEntry |=> seq_r == upac_pkg::ST_RUN
    ##1 !vbusDischarge) // [RL5]
    else $error("pass-through entry discharged VBUS");

  chk_entry_discharge: assert property (sDischEntry |=> seq_r == upac_pkg::ST_DISCH
    ##1 vbusDischarge && !portSwitchOn) // [RL6]
    else $error("mode entry without VBUS discharge");

  chk_discharge_error: assert property (seq_r == upac_pkg::ST_CHECK && !vbusLow && !reEntry
    && !(pwrFall && !curPass) |=> seq_r == upac_pkg::ST_ERROR ##1 dischargeError) // [RL22]
    else $error("failed discharge not flagged");

  chk_dminus_response: assert property (sCdpPrimary |=> dminusDrive) // [RL12]
    else $error("D- not driven after primary detection");

  chk_dminus_bound: assert property (respCnt_r < upac_pkg::RESP_CNT_W'(RespLimitCyc)) // [RL12]
    else $error("D- response exceeded limit");

  chk_dminus_release: assert property (cdpActive && !dpPrim && dpLow && dminusDrive
    |=> !dminusDrive ##1 !dminusDrive || dpPrim) // [RL13]
    else $error("D- not released after D+ low");

  chk_cdp_limit: assert property (cdpActive && limLow |=> ccLimitMode && hsSwitchClosed) // [RL10]
    else $error("downstream mode lost constant-current or switch");

  chk_dcp_profile: assert property (running && curMode_r == upac_pkg::MODE_DCP
    |=> dcpShortResistor && !hsSwitchClosed && !emuTimeoutEnable) // [RL17]
    else $error("dedicated profile outputs wrong");

  chk_cycle_retry: assert property (sDceTimeout |=> seq_r == upac_pkg::ST_DISCH) // [RL18]
    else $error("emulation cycle did not retry");

  chk_pass_persist: assert property (running && curPass && !modeChange
    |=> portSwitchOn && hsSwitchClosed && !ccLimitMode) // [RL2]
    else $error("pass-through not held");

  chk_removal_pulse: assert property (detEn && modeKnown_r && modeChange
    && curMode_r == upac_pkg::MODE_CDP |=> removalEvent) // [RL16]
    else $error("removal event missing on mode change");

endmodule

// file: sim/upac_portable_dev.sv
// Behavioural model of the portable device attached to the port.
// Assumes the controller's output levels and one shared clock; the bench steers it.
module upac_portable_dev (
  input wire logic sys_clk, // Clock
  input wire logic primReq, // Start a primary detection
  input wire logic chargeWanted, // Charge when a dedicated profile is seen
  input wire logic vbusStuck, // VBUS refuses to fall
  input wire logic vbusDischarge, // Discharge resistor on
  input wire logic portSwitchOn, // Port switch closed
  input wire logic dminusDrive, // 0.6 V driven on D-
  input wire logic dcpShortResistor, // D+ to D- short applied
  output logic dplusPrimary, // D+ in primary window
  output logic dplusLow, // D+ at zero
  output logic vbusBelowTest, // VBUS below test level
  output logic chargeCurrentDrawn // Load charging
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] holdCnt;

  initial begin
    dplusPrimary = 1'b0;
    dplusLow = 1'b1;
    vbusBelowTest = 1'b0;
    chargeCurrentDrawn = 1'b0;
    holdCnt = 4'h0;
  end

  // ----------------------------------------------------------------
  // VBUS level and charging
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    // Stuck VBUS lets the bench provoke a failed discharge
    if (vbusDischarge && !vbusStuck) begin
      vbusBelowTest <= 1'b1;
    end else if (portSwitchOn) begin
      vbusBelowTest <= 1'b0;
    end
    chargeCurrentDrawn <= chargeWanted && dcpShortResistor;
  end

  // ----------------------------------------------------------------
  // Primary detection; D- is never driven back by this load
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (primReq && !dplusPrimary && !dminusDrive) begin
      dplusPrimary <= 1'b1;
      dplusLow <= 1'b0;
      holdCnt <= 4'h0;
    end else if (dplusPrimary && dminusDrive) begin
      holdCnt <= holdCnt + 4'h1;
      if (holdCnt == 4'h5) begin
        dplusPrimary <= 1'b0;
        dplusLow <= 1'b1;
      end
    end
  end
endmodule

// file: sim/upac_active_ctrl_tb.sv
// Self-checking bench for the Active-mode sequencer.
// Assumes short discharge and timeout counts; the device model answers on D+.
module upac_active_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1;
  logic modeSelectA = 1'b1, modeSelectB = 1'b1, emulationEnableInput = 1'b0;
  logic portPowerEnable = 1'b1, detectFeatureSelect = 1'b0, currentLimitSettingLow = 1'b0;
  logic primReq = 1'b0, chargeWanted = 1'b1, vbusStuck = 1'b0;
  logic dplusPrimary, dplusLow, vbusBelowTest, chargeCurrentDrawn;
  logic portSwitchOn, vbusDischarge, hsSwitchClosed, ccLimitMode, dminusDrive;
  logic dcpShortResistor, emuTimeoutEnable, currentDrawRequired, dischargeError;
  logic dcpDetected, cdpHandshakeDone, removalEvent;
  logic [2:0] activeMode, code, prevCode;
  logic det, lim;
  upac_pkg::upac_mode_t m, pm;
  int errTotal = 0, checks = 0, discs, rems;

  always #4 sys_clk = ~sys_clk;

  upac_active_ctrl #(.DischCyc(8), .EmuTimeoutCyc(8), .RespLimitCyc(100)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .modeSelectA(modeSelectA),
    .modeSelectB(modeSelectB), .emulationEnableInput(emulationEnableInput),
    .portPowerEnable(portPowerEnable), .detectFeatureSelect(detectFeatureSelect),
    .dplusPrimary(dplusPrimary), .dplusLow(dplusLow), .vbusBelowTest(vbusBelowTest),
    .chargeCurrentDrawn(chargeCurrentDrawn), .currentLimitSettingLow(currentLimitSettingLow),
    .portSwitchOn(portSwitchOn), .vbusDischarge(vbusDischarge),
    .hsSwitchClosed(hsSwitchClosed), .ccLimitMode(ccLimitMode), .dminusDrive(dminusDrive),
    .dcpShortResistor(dcpShortResistor), .emuTimeoutEnable(emuTimeoutEnable),
    .currentDrawRequired(currentDrawRequired), .dischargeError(dischargeError),
    .dcpDetected(dcpDetected), .cdpHandshakeDone(cdpHandshakeDone),
    .removalEvent(removalEvent), .activeMode(activeMode));

  upac_portable_dev partner (
    .sys_clk(sys_clk), .primReq(primReq), .chargeWanted(chargeWanted), .vbusStuck(vbusStuck),
    .vbusDischarge(vbusDischarge), .portSwitchOn(portSwitchOn), .dminusDrive(dminusDrive),
    .dcpShortResistor(dcpShortResistor), .dplusPrimary(dplusPrimary), .dplusLow(dplusLow),
    .vbusBelowTest(vbusBelowTest), .chargeCurrentDrawn(chargeCurrentDrawn));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic upac_pkg::upac_mode_t expMode(input logic [2:0] c);
    case (c)
      upac_pkg::CODE_DCE_A, upac_pkg::CODE_DCE_B: return upac_pkg::MODE_DCE;
      upac_pkg::CODE_DCP: return upac_pkg::MODE_DCP;
      upac_pkg::CODE_SDP: return upac_pkg::MODE_SDP;
      upac_pkg::CODE_CDP: return upac_pkg::MODE_CDP;
      default: return upac_pkg::MODE_PASS;
    endcase
  endfunction

  task automatic test_done;
    $display("Checks %0d errors %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Count discharge and removal cycles while the sequencer runs
  task automatic settle(input int n);
    discs = 0;
    rems = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      if (vbusDischarge === 1'b1) discs++;
      if (removalEvent === 1'b1) rems++;
    end
  endtask

  task automatic waitDm(input logic want);
    int k;
    for (k = 0; k < 100 && dminusDrive !== want; k++) begin
      @(posedge sys_clk);
      #1;
    end
    if (k == 100) begin
      errTotal++;
      $display("Error dminusDrive wait expected %0h seen timeout", want);
      test_done();
    end
  endtask

  task automatic setCode(input logic [2:0] c);
    {modeSelectA, modeSelectB, emulationEnableInput} = c;
    settle(30);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(3));
    repeat (5) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    settle(10);
    prevCode = upac_pkg::CODE_PASS_C;
    // Every code once, then random codes with random limit and detect settings
    for (int i = 0; i < 16; i++) begin
      code = (i < 8) ? 3'(i) : 3'($urandom % 8);
      det = 1'($urandom % 2);
      lim = 1'($urandom % 2);
      m = expMode(code);
      pm = expMode(prevCode);
      detectFeatureSelect = det;
      currentLimitSettingLow = lim;
      setCode(code);
      chk("activeMode", 8'(activeMode), 8'(m));
      chk("portSwitchOn", 8'(portSwitchOn), 8'h01);
      chk("hsSwitchClosed", 8'(hsSwitchClosed),
          8'(m inside {upac_pkg::MODE_PASS, upac_pkg::MODE_SDP, upac_pkg::MODE_CDP}));
      chk("ccLimitMode", 8'(ccLimitMode),
          8'(lim && !(m inside {upac_pkg::MODE_PASS, upac_pkg::MODE_SDP})));
      chk("dcpShortResistor", 8'(dcpShortResistor),
          8'(m inside {upac_pkg::MODE_DCP, upac_pkg::MODE_DCE}));
      chk("discharged", 8'(discs != 0), 8'(m != pm && m != upac_pkg::MODE_PASS));
      chk("removalEvent", 8'(rems), 8'(pm == upac_pkg::MODE_CDP && m != pm && det));
      if (m == upac_pkg::MODE_DCP) begin
        chk("emuTimeoutEnable", 8'(emuTimeoutEnable), 8'h00);
      end
      if (m == upac_pkg::MODE_DCE) begin
        chk("dcpDetected", 8'(dcpDetected), 8'h01);
      end
      prevCode = code;
    end

    // Handshake twice, the second one a renegotiation
    detectFeatureSelect = 1'b1;
    currentLimitSettingLow = 1'b1;
    setCode(upac_pkg::CODE_CDP);
    settle(20);
    chk("removalEvent", 8'(rems), 8'h00);
    repeat (2) begin
      primReq = 1'b1;
      waitDm(1'b1);
      primReq = 1'b0;
      chk("hsSwitchClosed", 8'(hsSwitchClosed), 8'h01);
      waitDm(1'b0);
      chk("cdpHandshakeDone", 8'(cdpHandshakeDone), 8'h01);
      chk("ccLimitMode", 8'(ccLimitMode), 8'h01);
      settle(10);
      chk("dminusDrive", 8'(dminusDrive), 8'h00);
    end

    // Power toggles in a charging mode and in pass-through
    portPowerEnable = 1'b0;
    settle(10);
    chk("portSwitchOn", 8'(portSwitchOn), 8'h00);
    chk("removalEvent", 8'(rems), 8'h01);
    portPowerEnable = 1'b1;
    settle(30);
    chk("discharged", 8'(discs != 0), 8'h01);
    setCode(upac_pkg::CODE_PASS_A);
    chk("discharged", 8'(discs), 8'h00);
    portPowerEnable = 1'b0;
    settle(10);
    chk("portSwitchOn", 8'(portSwitchOn), 8'h01);
    chk("hsSwitchClosed", 8'(hsSwitchClosed), 8'h01);
    portPowerEnable = 1'b1;
    settle(5);

    // Failed discharge, then recovery by re-entry
    vbusStuck = 1'b1;
    setCode(upac_pkg::CODE_SDP);
    chk("dischargeError", 8'(dischargeError), 8'h01);
    vbusStuck = 1'b0;
    setCode(upac_pkg::CODE_CDP);
    chk("dischargeError", 8'(dischargeError), 8'h00);
    // Frozen block ignores a power toggle on its pins
    clkEn = 1'b0;
    portPowerEnable = 1'b0;
    settle(10);
    chk("frozenSwitch", 8'(portSwitchOn), 8'h01);
    portPowerEnable = 1'b1;
    settle(2);
    clkEn = 1'b1;
    settle(5);
    chk("frozenRemoval", 8'(rems), 8'h00);

    // Emulation cycle with a load that never charges keeps retrying
    chargeWanted = 1'b0;
    setCode(upac_pkg::CODE_DCE_B);
    for (int k = 0; k < 40 && dcpShortResistor !== 1'b1; k++) settle(1);
    if (dcpShortResistor !== 1'b1) begin
      chk("dcpShortResistor", 8'(dcpShortResistor), 8'h01);
      test_done();
    end
    chk("emuTimeoutEnable", 8'(emuTimeoutEnable), 8'h01);
    chk("currentDrawRequired", 8'(currentDrawRequired), 8'h01);
    chk("hsSwitchClosed", 8'(hsSwitchClosed), 8'h00);
    chk("dcpDetected", 8'(dcpDetected), 8'h00);
    settle(40);
    chk("retryDischarge", 8'(discs != 0), 8'h01);
    test_done();
  end
endmodule
